// >>> shared/usart_map.svh
// register map, field masks, reset values and bit timing of the serial port
// Operation
// - full duplex when asynchronous, half duplex when synchronous, as master or slave
// - transmit control bit 4 picks synchronous (1) or asynchronous (0) operation
// - bit 7 in synchronous mode: 1 master drives clock, 0 slave takes it
// - transmit control bit 6 selects nine-bit frames, clear gives eight bits
// - bit 5 enables transmit; in synchronous mode receive enables override it
// - bit 2 picks fast or slow divisor when asynchronous, ignored when synchronous
// - read-only bit 1 is 1 while transmit shifter empty, resets to 1
// - transmit control bit 0 holds ninth bit to send, usable as parity
// - receive control bit 7 hands both pins to the serial port
// - receive control bit 6 selects nine-bit reception
// - bit 5 starts one synchronous master reception, cleared by hardware after it
// - bit 4 enables reception; in synchronous mode keeps receiving, overrides bit 5
// - nine-bit asynchronous with bit 3 set accepts only bytes whose bit 8 is 1
// - read-only bit 2 shows framing error of the byte in the buffer
// - read-only bit 1 flags overrun, cleared only by clearing bit 4
// - receive control bit 0 holds received ninth bit; no hardware parity
// - a free-running 8-bit timer, period set by the divisor, times both modes
// - writing the divisor restarts the baud timer at once
// - rate is clock/(64(X+1)) slow, /(16(X+1)) fast, /(4(X+1)) synchronous
// - when asynchronous the receive pin is sampled three times per bit, majority decides; synchronous takes one sample
`ifndef USART_MAP_SVH
`define USART_MAP_SVH

// register indices; byte address is four times the index
`define RX_CTL_IDX     8'h18
`define TX_CTL_IDX     8'h98
`define DIV_IDX        8'h99
`define TX_DATA_IDX    8'hA0
`define RX_DATA_IDX    8'hA1
`define LINE_STAT_IDX  8'hA2

// writable fields and reset values
`define TX_CTL_WMASK   8'hF5
`define RX_CTL_WMASK   8'hF8
`define TX_CTL_RST     8'h02
`define RX_CTL_RST     8'h00
`define DIV_RST        8'h00
`define CONT_RX_POS    4

// baud timer runs one step per two clocks; sync half bit is one overflow
`define BAUD_PRESCALE  2
`define TICKS_BIT_HI   6'h08
`define TICKS_BIT_LO   6'h20

`endif

// >>> shared/usart_pkg.sv
// types shared by the serial port design files
package usart_pkg;

	typedef struct packed {
		logic clockSourceMaster;
		logic transmitNinthEnable;
		logic transmitEnable;
		logic syncMode;
		logic unused3;
		logic highSpeedSelect;
		logic shifterEmptyFlag;
		logic transmitNinthData;
	} txCtl_t;

	typedef struct packed {
		logic portEnable;
		logic receiveNinthEnable;
		logic singleReceiveEnable;
		logic continuousReceiveEnable;
		logic addressDetectEnable;
		logic framingErrorFlag;
		logic overrunErrorFlag;
		logic receivedNinthData;
	} rxCtl_t;

	typedef enum logic [1:0] {
		SH_IDLE  = 2'b00,
		SH_START = 2'b01,
		SH_DATA  = 2'b10,
		SH_STOP  = 2'b11
	} shState_t;

endpackage : usart_pkg

// >>> design/usart_baud_gen.sv
// free-running baud timer with prescaler and restart
`timescale 1ns/1ps
`include "usart_map.svh"
module usart_baud_gen #(
	parameter int W = 8
)(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         restart,
	input  wire logic [W-1:0] divisor,
	output logic              tick
);
	if (W < 1) begin : gBadW
		$error("usart_baud_gen: W must be at least 1");
	end

	logic         preQ;
	logic [W-1:0] timerQ;

	// one overflow every prescale*(X+1) clocks
	always_ff @(posedge ref_clk) begin
		if (rst || restart) begin
			preQ   <= 1'b0;
			timerQ <= '0;
			tick   <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (preQ == 1'(`BAUD_PRESCALE - 1)) begin
				preQ <= 1'b0;
				if (timerQ == divisor) begin
					timerQ <= '0;
					tick   <= 1'b1;
				end else begin
					timerQ <= timerQ + 1'b1;
				end
			end else begin
				preQ <= preQ + 1'b1;
			end
		end
	end
endmodule : usart_baud_gen

// >>> design/usart_majority_vote.sv
// receive pin synchroniser with three-sample majority vote
`timescale 1ns/1ps
module usart_majority_vote (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pinAsync,
	input  wire logic strobe,
	output logic      pinSync,
	output logic      vote
);
	logic       metaQ;
	logic [2:0] sampleQ;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			metaQ   <= 1'b1;
			pinSync <= 1'b1;
			sampleQ <= 3'h7;
		end else begin
			metaQ   <= pinAsync;
			pinSync <= metaQ;
			if (strobe) begin
				sampleQ <= {sampleQ[1:0], pinSync};
			end
		end
	end

	// a single noisy sample cannot flip the decided level
	assign vote = (sampleQ[0] & sampleQ[1]) | (sampleQ[0] & sampleQ[2]) |
		(sampleQ[1] & sampleQ[2]);
endmodule : usart_majority_vote

// >>> design/usart_ctrl.sv
// serial port: registers, baud timing, async and sync shifters, pin control
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usart_map.svh"
module usart_ctrl
	import usart_pkg::*;
#(
	parameter int AW = 12
)(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	input  wire logic          receiveDataPinIn,
	output logic               receiveDataPinOut,
	output logic               receiveDataPinOe,
	input  wire logic          transmitClockPinIn,
	output logic               transmitClockPinOut,
	output logic               transmitClockPinOe
);
	if (AW < 10) begin : gBadAw
		$error("usart_ctrl: AW must be at least 10");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	txCtl_t     txCtlQ;
	rxCtl_t     rxCtlQ;
	logic [7:0] divisorQ;
	logic [7:0] txBufQ;
	logic       txBufFullQ;
	logic [7:0] rxDataQ;
	logic       rxReadyQ;
	shState_t   txStQ;
	shState_t   rxStQ;
	logic [8:0] txShQ;
	logic [8:0] rxShQ;
	logic [3:0] txBitQ;
	logic [3:0] rxBitQ;
	logic [5:0] txTickQ;
	logic [5:0] rxTickQ;
	logic       txLineQ;
	logic       clkPhaseQ;
	logic       rxDoneQ;
	logic [8:0] rxCapQ;
	logic       ferrCapQ;
	logic       clkMetaQ;
	logic       clkSyncQ;
	logic       clkPrevQ;
	logic          awGotQ;
	logic          wGotQ;
	logic [AW-1:0] awAddrQ;
	logic [7:0]    wDataQ;
	logic          wStrb0Q;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	wire       doWrite  = awGotQ & wGotQ & ~bvalid;
	wire [7:0] wIdx     = awAddrQ[9:2];
	wire       wHigh0   = (awAddrQ >> 10) == '0;
	wire       wHitRx   = wHigh0 & (wIdx == `RX_CTL_IDX);
	wire       wHitTx   = wHigh0 & (wIdx == `TX_CTL_IDX);
	wire       wHitDiv  = wHigh0 & (wIdx == `DIV_IDX);
	wire       wHitTd   = wHigh0 & (wIdx == `TX_DATA_IDX);
	wire       wHitRd   = wHigh0 & (wIdx == `RX_DATA_IDX);
	wire       wHitLs   = wHigh0 & (wIdx == `LINE_STAT_IDX);
	wire       wHitAny  = wHitRx | wHitTx | wHitDiv | wHitTd | wHitRd | wHitLs;
	wire       wrEn     = doWrite & wStrb0Q;
	wire       wrRxCtl  = wrEn & wHitRx;
	wire       wrTxCtl  = wrEn & wHitTx;
	wire       wrDiv    = wrEn & wHitDiv;
	wire       wrTxData = wrEn & wHitTd;

	wire       rdTake   = arvalid & arready;
	wire [7:0] rIdx     = araddr[9:2];
	wire       rHigh0   = (araddr >> 10) == '0;
	wire       rHitRx   = rHigh0 & (rIdx == `RX_CTL_IDX);
	wire       rHitTx   = rHigh0 & (rIdx == `TX_CTL_IDX);
	wire       rHitDiv  = rHigh0 & (rIdx == `DIV_IDX);
	wire       rHitTd   = rHigh0 & (rIdx == `TX_DATA_IDX);
	wire       rHitRd   = rHigh0 & (rIdx == `RX_DATA_IDX);
	wire       rHitLs   = rHigh0 & (rIdx == `LINE_STAT_IDX);
	wire       rHitAny  = rHitRx | rHitTx | rHitDiv | rHitTd | rHitRd | rHitLs;
	wire       rdRxData = rdTake & rHitRd;

	////////////////////////////////////////////////////////////////////////////
	// mode decode

	wire portOn   = rxCtlQ.portEnable;
	wire syncOn   = txCtlQ.syncMode;
	wire master   = syncOn & txCtlQ.clockSourceMaster;
	wire contRx   = rxCtlQ.continuousReceiveEnable;
	wire overrun  = rxCtlQ.overrunErrorFlag;
	// single receive only counts for a sync master
	wire rxSyncReq = syncOn & (contRx | (master & rxCtlQ.singleReceiveEnable));
	wire txSyncOk  = syncOn & txCtlQ.transmitEnable & ~rxSyncReq;
	wire [3:0] lastTx = txCtlQ.transmitNinthEnable ? 4'h8 : 4'h7;
	wire [3:0] lastRx = rxCtlQ.receiveNinthEnable ? 4'h8 : 4'h7;
	wire [5:0] bitTicks = txCtlQ.highSpeedSelect ? `TICKS_BIT_HI : `TICKS_BIT_LO;
	wire [5:0] bitLast  = bitTicks - 6'h01;
	wire [5:0] halfTick = bitTicks >> 1;
	wire       shifterEmpty = (txStQ == SH_IDLE);

	logic tick;
	logic dataSync;
	logic dataVote;

	wire txEnd = tick & ~syncOn & (txTickQ == bitLast);
	wire rxEnd = tick & ~syncOn & (rxTickQ == bitLast);
	// three samples straddle the middle of each bit
	wire voteStrobe = tick & ~syncOn & (rxStQ != SH_IDLE) &
		(rxTickQ >= halfTick - 6'h01) & (rxTickQ <= halfTick + 6'h01);

	wire syncBusy  = (txStQ != SH_IDLE) | (rxStQ != SH_IDLE);
	wire slaveRise = clkSyncQ & ~clkPrevQ;
	wire slaveFall = ~clkSyncQ & clkPrevQ;
	wire riseEv = syncOn & (master ? (tick & ~clkPhaseQ & syncBusy) : slaveRise);
	wire fallEv = syncOn & (master ? (tick & clkPhaseQ) : slaveFall);

	wire txLoad = (txStQ == SH_IDLE) & txBufFullQ & portOn &
		(syncOn ? txSyncOk : txCtlQ.transmitEnable);
	wire txAbort = ~portOn | (syncOn & rxSyncReq);
	wire rxAbort = ~portOn | (syncOn ? ~rxSyncReq : ~contRx);
	wire rxAsyncGo = ~syncOn & contRx & ~overrun & ~dataSync;
	wire rxSyncGo  = rxSyncReq & ~overrun & (txStQ == SH_IDLE);
	wire [8:0] rxShNext = {syncOn ? dataSync : dataVote, rxShQ[8:1]};
	wire syncFinish = (rxStQ == SH_DATA) & riseEv & (rxBitQ == lastRx);
	wire singleRxDone = syncFinish & master & ~contRx;

	// address match only on nine-bit async frames with the flag set
	wire rxAccept = ~(~syncOn & rxCtlQ.receiveNinthEnable &
		rxCtlQ.addressDetectEnable & ~rxCapQ[8]);
	wire rxFull = rxReadyQ & ~rdRxData;

	wire [7:0] txCtlRead = {txCtlQ.clockSourceMaster, txCtlQ.transmitNinthEnable,
		txCtlQ.transmitEnable, txCtlQ.syncMode, 1'b0, txCtlQ.highSpeedSelect,
		shifterEmpty, txCtlQ.transmitNinthData};
	wire [7:0] rdByte = rHitRx ? rxCtlQ :
		rHitTx ? txCtlRead :
		rHitDiv ? divisorQ :
		rHitRd ? rxDataQ :
		rHitLs ? {6'h00, txBufFullQ, rxReadyQ} : 8'h00;

	function automatic logic [8:0] alignRx(input logic [8:0] sh, input logic nine);
		alignRx = nine ? sh : {1'b0, sh[8:1]};
	endfunction : alignRx

	////////////////////////////////////////////////////////////////////////////
	// helpers

	usart_baud_gen #(
		.W (8)
	) uBaud (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (wrDiv),
		.divisor (divisorQ),
		.tick    (tick)
	);

	usart_majority_vote uVote (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.pinAsync (receiveDataPinIn),
		.strobe   (voteStrobe),
		.pinSync  (dataSync),
		.vote     (dataVote)
	);

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: one write and one read at a time

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			awGotQ  <= 1'b0;
			wGotQ   <= 1'b0;
			awAddrQ <= '0;
			wDataQ  <= 8'h00;
			wStrb0Q <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				awGotQ  <= 1'b1;
				awAddrQ <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wGotQ   <= 1'b1;
				wDataQ  <= wdata[7:0];
				wStrb0Q <= wstrb[0];
				wready  <= 1'b0;
			end
			if (doWrite) begin
				awGotQ <= 1'b0;
				wGotQ  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wHitAny ? 2'h0 : 2'h2;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= 2'h0;
		end else if (rdTake) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h00_0000, rdByte};
			rresp   <= rHitAny ? 2'h0 : 2'h2;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txCtlQ     <= `TX_CTL_RST;
			divisorQ   <= `DIV_RST;
			txBufQ     <= 8'h00;
			txBufFullQ <= 1'b0;
		end else begin
			if (wrTxCtl) begin
				txCtlQ <= (wDataQ & `TX_CTL_WMASK) | (txCtlQ & ~`TX_CTL_WMASK);
			end
			if (wrDiv) begin
				divisorQ <= wDataQ;
			end
			if (txLoad) begin
				txBufFullQ <= 1'b0;
			end
			// a write in the load cycle refills the buffer
			if (wrTxData) begin
				txBufQ     <= wDataQ;
				txBufFullQ <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxCtlQ   <= `RX_CTL_RST;
			rxDataQ  <= 8'h00;
			rxReadyQ <= 1'b0;
		end else begin
			if (singleRxDone) begin
				rxCtlQ.singleReceiveEnable <= 1'b0;
			end
			if (wrRxCtl) begin
				rxCtlQ <= (wDataQ & `RX_CTL_WMASK) | (rxCtlQ & ~`RX_CTL_WMASK);
				if (!wDataQ[`CONT_RX_POS]) begin
					rxCtlQ.overrunErrorFlag <= 1'b0;
				end
			end
			if (rdRxData) begin
				rxReadyQ <= 1'b0;
			end
			// a new byte wins over a read or a clear in the same cycle
			if (rxDoneQ && rxAccept) begin
				if (rxFull) begin
					rxCtlQ.overrunErrorFlag <= 1'b1;
				end else begin
					rxDataQ                  <= rxCapQ[7:0];
					rxCtlQ.receivedNinthData <= rxCapQ[8];
					rxCtlQ.framingErrorFlag  <= ferrCapQ;
					rxReadyQ                 <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmitter

	always_ff @(posedge ref_clk) begin
		if (rst || txStQ == SH_IDLE) begin
			txTickQ <= 6'h00;
		end else if (tick && !syncOn) begin
			txTickQ <= txEnd ? 6'h00 : txTickQ + 6'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txStQ   <= SH_IDLE;
			txShQ   <= 9'h000;
			txBitQ  <= 4'h0;
			txLineQ <= 1'b1;
		end else if (txAbort) begin
			txStQ   <= SH_IDLE;
			txLineQ <= 1'b1;
		end else begin
			case (txStQ)
				SH_IDLE: begin
					txLineQ <= 1'b1;
					txBitQ  <= 4'h0;
					if (txLoad) begin
						txShQ <= {txCtlQ.transmitNinthData, txBufQ};
						if (syncOn) begin
							txLineQ <= txBufQ[0];
							txStQ   <= SH_DATA;
						end else begin
							txLineQ <= 1'b0;
							txStQ   <= SH_START;
						end
					end
				end
				SH_START: begin
					if (txEnd) begin
						txLineQ <= txShQ[0];
						txStQ   <= SH_DATA;
					end
				end
				SH_DATA: begin
					if (syncOn ? fallEv : txEnd) begin
						if (txBitQ == lastTx) begin
							txLineQ <= 1'b1;
							txStQ   <= syncOn ? SH_IDLE : SH_STOP;
						end else begin
							txShQ   <= txShQ >> 1;
							txLineQ <= txShQ[1];
							txBitQ  <= txBitQ + 4'h1;
						end
					end
				end
				SH_STOP: begin
					if (txEnd) begin
						txStQ <= SH_IDLE;
					end
				end
				default: begin
					txStQ <= SH_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receiver

	always_ff @(posedge ref_clk) begin
		if (rst || rxStQ == SH_IDLE) begin
			rxTickQ <= 6'h00;
		end else if (tick && !syncOn) begin
			rxTickQ <= rxEnd ? 6'h00 : rxTickQ + 6'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxStQ    <= SH_IDLE;
			rxShQ    <= 9'h000;
			rxBitQ   <= 4'h0;
			rxDoneQ  <= 1'b0;
			rxCapQ   <= 9'h000;
			ferrCapQ <= 1'b0;
		end else begin
			rxDoneQ <= 1'b0;
			if (rxAbort) begin
				rxStQ <= SH_IDLE;
			end else begin
				case (rxStQ)
					SH_IDLE: begin
						rxBitQ <= 4'h0;
						if (!syncOn && rxAsyncGo) begin
							rxStQ <= SH_START;
						end else if (syncOn && rxSyncGo) begin
							rxStQ <= SH_DATA;
						end
					end
					SH_START: begin
						// a start bit that voted high was a glitch
						if (rxEnd) begin
							rxStQ <= dataVote ? SH_IDLE : SH_DATA;
						end
					end
					SH_DATA: begin
						if (syncOn ? riseEv : rxEnd) begin
							rxShQ  <= rxShNext;
							rxBitQ <= rxBitQ + 4'h1;
							if (rxBitQ == lastRx) begin
								if (syncOn) begin
									rxCapQ   <= alignRx(rxShNext, rxCtlQ.receiveNinthEnable);
									ferrCapQ <= 1'b0;
									rxDoneQ  <= 1'b1;
									rxStQ    <= SH_IDLE;
								end else begin
									rxStQ <= SH_STOP;
								end
							end
						end
					end
					SH_STOP: begin
						if (rxEnd) begin
							rxCapQ   <= alignRx(rxShQ, rxCtlQ.receiveNinthEnable);
							ferrCapQ <= ~dataVote;
							rxDoneQ  <= 1'b1;
							rxStQ    <= SH_IDLE;
						end
					end
					default: begin
						rxStQ <= SH_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sync clock and pins

	// the slave clock comes from the far side, so it is synchronised first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clkMetaQ <= 1'b0;
			clkSyncQ <= 1'b0;
			clkPrevQ <= 1'b0;
		end else begin
			clkMetaQ <= transmitClockPinIn;
			clkSyncQ <= clkMetaQ;
			clkPrevQ <= clkSyncQ;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !master || !portOn) begin
			clkPhaseQ <= 1'b0;
		end else if (tick && (syncBusy || clkPhaseQ)) begin
			clkPhaseQ <= ~clkPhaseQ;
		end
	end

	// both pins lag their sources by one clock alike
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			receiveDataPinOut   <= 1'b1;
			receiveDataPinOe    <= 1'b0;
			transmitClockPinOut <= 1'b1;
			transmitClockPinOe  <= 1'b0;
		end else begin
			receiveDataPinOut   <= txLineQ;
			receiveDataPinOe    <= portOn & syncOn & (txStQ != SH_IDLE);
			transmitClockPinOut <= syncOn ? clkPhaseQ : txLineQ;
			transmitClockPinOe  <= portOn & (~syncOn | master);
		end
	end
endmodule : usart_ctrl

// >>> verification/usart_ctrl_properties.sv
// bus handshake and pin properties of the serial port
`timescale 1ns/1ps
module usart_ctrl_properties #(
	parameter int AW = 12
)(
	input wire logic          ref_clk,
	input wire logic          rst,
	input wire logic [AW-1:0] awaddr,
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic [1:0]    bresp,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic [AW-1:0] araddr,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic [31:0]   rdata,
	input wire logic [1:0]    rresp,
	input wire logic          rvalid,
	input wire logic          rready,
	input wire logic          transmitClockPinOe,
	input wire logic          receiveDataPinOe
);
	// unmapped indices answer with an error code
	function automatic logic [1:0] respFor(input logic [AW-1:0] a);
		return (a[AW-1:10] == 0 && a[9:2] inside {8'h18, 8'h98, 8'h99, 8'hA0, 8'hA1, 8'hA2})
			? 2'h0 : 2'h2;
	endfunction : respFor
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	//////////////////////////////////////////////////////////////////////////////////////////
	a_reset_idle: assert property (disable iff (1'b0) rst |=> awready && arready && !bvalid
		&& !rvalid && !transmitClockPinOe && !receiveDataPinOe) else $error("reset state wrong");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready
		&& rresp == respFor($past(araddr))) else $error("read answer wrong");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid
		##1 bvalid && bresp == respFor($past(awaddr, 2))) else $error("write answer wrong");
	a_write_refused: assert property (awvalid && awready && wvalid && wready
		|=> !awready && !wready) else $error("write taken twice");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_b_return: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not released");
	a_r_return: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not released");
endmodule : usart_ctrl_properties

// >>> verification/serial_terminal.sv
// asynchronous terminal on the serial line
`timescale 1ns/1ps
module serial_terminal (
	input wire logic lineIn,
	output logic     lineOut
);
	int         bitNs   = 640;
	int         rxBits  = 8;
	int         rxCount = 0;
	logic [8:0] rxData  = 9'h000;
	initial lineOut = 1'b1;
	//////////////////////////////////////////////////////////////////////////////////////////
	// low start, bits lsb first, stop level chosen by the caller
	task send(input logic [8:0] d, input int nb, input logic stopLvl);
		lineOut <= 1'b0;
		#(bitNs);
		for (int i = 0; i < nb; i++) begin
			lineOut <= d[i];
			#(bitNs);
		end
		lineOut <= stopLvl;
		#(bitNs);
		lineOut <= 1'b1;
		#(bitNs);
	endtask : send
	// mid-bit sampling; start rechecked so a glitch is not taken for a frame
	always @(negedge lineIn) begin
		#(bitNs / 2);
		if (!lineIn) begin
			rxData = 9'h000;
			for (int i = 0; i < rxBits; i++) begin
				#(bitNs);
				rxData[i] = lineIn;
			end
			#(bitNs);
			if (lineIn) rxCount++;
		end
	end
endmodule : serial_terminal

// >>> verification/usart_ctrl_test.sv
// self-checking bench for the serial port registers and async line
`timescale 1ns/1ps
module usart_ctrl_test;
	logic        ref_clk = 1'b0, rst = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rdVal;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, respVal;
	logic        awready, wready, bvalid, arready, rvalid, termLine, txLine;
	logic        receiveDataPinOut, receiveDataPinOe, transmitClockPinOut, transmitClockPinOe;
	wire         receiveDataPinIn, transmitClockPinIn;
	int          err_count = 0, comparisons = 0, cnt, n;
	logic [7:0]  ctl;
	logic        linkClk = 1'b0, linkData = 1'b1, prevClk;
	always #20 ref_clk = ~ref_clk;
	// idle line is pulled up while the port does not drive it
	assign txLine = transmitClockPinOe ? transmitClockPinOut : 1'b1;
	assign receiveDataPinIn = receiveDataPinOe ? receiveDataPinOut : termLine & linkData;
	assign transmitClockPinIn = transmitClockPinOe ? transmitClockPinOut : linkClk;
	serial_terminal partner (.lineIn(txLine), .lineOut(termLine));
	usart_ctrl #(.AW(12)) dut (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .receiveDataPinIn, .receiveDataPinOut, .receiveDataPinOe,
		.transmitClockPinIn, .transmitClockPinOut, .transmitClockPinOe);
	//////////////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task hang;
		err_count++;
		stop_test();
	endtask : hang
	task chk(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t expected %h got %h", $time, exp, got);
		end
	endtask : chk
	task wr(input logic [7:0] idx, input logic [7:0] d);
		int k;
		logic aw, w;
		k = 0;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge ref_clk);
			if (aw && awready === 1'b1) begin aw = 1'b0; awvalid <= 1'b0; end
			if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
			if (++k > 100) hang();
		end
		bready <= 1'b1;
		do begin @(posedge ref_clk); if (++k > 200) hang(); end while (bvalid !== 1'b1);
		respVal = bresp;
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] idx);
		int k;
		k = 0;
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		do begin @(posedge ref_clk); if (++k > 100) hang(); end while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin @(posedge ref_clk); if (++k > 200) hang(); end while (rvalid !== 1'b1);
		rdVal = rdata;
		respVal = rresp;
		rready <= 1'b0;
	endtask : rd
	task rdchk(input logic [7:0] idx, input logic [31:0] exp);
		rd(idx);
		chk(exp, rdVal);
	endtask : rdchk
	task tx(input logic [8:0] d, input int nb, input logic stopLvl);
		partner.send(d, nb, stopLvl);
		@(posedge ref_clk);
	endtask : tx
	// polls the line status ready bit
	task waitReady;
		int k;
		k = 0;
		do begin rd(8'hA2); if (++k > 300) hang(); end while (rdVal[0] !== 1'b1);
	endtask : waitReady
	//////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk(8'h18, 32'h00);
		rdchk(8'h98, 32'h02);
		rdchk(8'h99, 32'h00);
		wr(8'h98, 8'hFF);
		rdchk(8'h98, 32'hF7);
		wr(8'h98, 8'h00);
		wr(8'h18, 8'h6F);
		rdchk(8'h18, 32'h68);
		wr(8'h99, 8'hA5);
		rdchk(8'h99, 32'hA5);
		wr(8'h99, 8'h00);
		rd(8'h00);
		chk(32'h2, {30'h0, respVal});
		wr(8'h01, 8'hFF);
		chk(32'h2, {30'h0, respVal});
		// pin direction comes from the block's enable outputs; the port enable and continuous receive are set here
		wr(8'h18, 8'h90);
		for (int m = 0; m < 2; m++) begin
			ctl = m ? 8'h20 : 8'h24;
			partner.bitNs = m ? 2560 : 640;
			cnt = partner.rxCount;
			wr(8'h98, ctl);
			wr(8'hA0, 8'h5A);
			rdchk(8'h98, {24'h0, ctl});
			n = 0;
			while (partner.rxCount == cnt) begin @(posedge ref_clk); if (++n > 3000) hang(); end
			chk(32'h5A, {23'h0, partner.rxData});
			#(partner.bitNs);
			@(posedge ref_clk);
			rdchk(8'h98, {24'h0, ctl | 8'h02});
		end
		partner.bitNs = 640;
		wr(8'h98, 8'h24);
		tx(9'h0A5, 8, 1'b0);
		waitReady();
		rdchk(8'h18, 32'h94);
		rdchk(8'hA1, 32'hA5);
		tx(9'h0C3, 8, 1'b1);
		waitReady();
		rdchk(8'hA1, 32'hC3);
		rdchk(8'h18, 32'h90);
		wr(8'h18, 8'hD8);
		tx(9'h033, 9, 1'b1);
		repeat (32) @(posedge ref_clk);
		rdchk(8'hA2, 32'h0);
		tx(9'h1C7, 9, 1'b1);
		waitReady();
		rdchk(8'h18, 32'hD9);
		rdchk(8'hA1, 32'hC7);
		wr(8'h18, 8'h90);
		tx(9'h011, 8, 1'b1);
		tx(9'h022, 8, 1'b1);
		repeat (32) @(posedge ref_clk);
		rdchk(8'hA1, 32'h11);
		rdchk(8'h18, 32'h92);
		wr(8'h18, 8'h80);
		rdchk(8'h18, 32'h80);
		// sync master sends one byte, taken at each rising clock on the pin
		wr(8'h98, 8'hB0);
		wr(8'hA0, 8'h5A);
		n = 0;
		cnt = 0;
		prevClk = 1'b0;
		while (cnt < 8) begin
			@(posedge ref_clk);
			if (transmitClockPinOut && !prevClk) begin
				ctl = {receiveDataPinOut, ctl[7:1]};
				cnt++;
			end
			prevClk = transmitClockPinOut;
			if (++n > 500) hang();
		end
		chk(32'h5A, {24'h0, ctl});
		wr(8'h18, 8'hA0);
		waitReady();
		rdchk(8'h18, 32'h80);
		rdchk(8'hA1, 32'hFF);
		// slave: bench clock of 320 ns, still outside the frame
		wr(8'h98, 8'h10);
		wr(8'h18, 8'h90);
		for (int i = 0; i < 8; i++) begin
			linkData <= 1'(8'h3C >> i);
			repeat (4) @(posedge ref_clk);
			linkClk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			linkClk <= 1'b0;
		end
		waitReady();
		rdchk(8'hA1, 32'h3C);
		stop_test();
	end
endmodule : usart_ctrl_test
bind usart_ctrl usart_ctrl_properties #(.AW(AW)) props (.ref_clk, .rst, .awaddr, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready, .transmitClockPinOe, .receiveDataPinOe);
